// >>> verilog/ubs_pkg.sv
// Purpose: Shared constants and types for the serial baud and shift block.
// Assumes: One register word per index on an 8-bit plain register port.
// Notes: Phase numbers count S1P1 as 0 up to S6P2 as 11.
package ubs_pkg;
  // Register indices.
  localparam logic [2:0] ADDR_SCTRL = 3'h0;
  localparam logic [2:0] ADDR_SER_BUF = 3'h1;
  localparam logic [2:0] ADDR_PCTRL = 3'h2;
  localparam logic [2:0] ADDR_TMODE = 3'h3;
  localparam logic [2:0] ADDR_T1RLD = 3'h4;
  localparam logic [2:0] ADDR_T2CTRL = 3'h5;
  localparam logic [2:0] ADDR_CKMODE = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;
  // Serial control fields.
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int RX_ENABLE_BIT = 4;
  localparam int TX_NINTH_BIT = 3;
  localparam int RX_NINTH_BIT = 2;
  localparam int TX_DONE_BIT = 1;
  localparam int RX_DONE_BIT = 0;
  // Other control fields.
  localparam int DOUBLER_BIT = 7;
  localparam int T2_RX_CLK_BIT = 5;
  localparam int T2_TX_CLK_BIT = 4;
  localparam int SIX_CLOCK_BIT = 0;
  localparam int T1_RUN_BIT = 1;
  localparam logic [3:0] T1_AUTO_RELOAD = 4'h2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Machine-cycle phase numbers.
  localparam logic [3:0] PH_S1P1 = 4'h0;
  localparam logic [3:0] PH_S3P1 = 4'h4;
  localparam logic [3:0] PH_S5P2 = 4'h9;
  localparam logic [3:0] PH_S6P2 = 4'hB;
  localparam logic [3:0] PH_LAST = 4'hB;
  // Bit-rate divisors and shift-register preloads.
  localparam logic [6:0] MODE2_DIV = 7'h40;
  localparam logic [6:0] T1_BAUD_DIV = 7'h20;
  localparam logic [3:0] T2_BAUD_LAST = 4'hF;
  localparam logic [3:0] T1_PRESCALE_LAST = 4'hB;
  localparam logic [7:0] RX_PRELOAD = 8'hFE;
  localparam logic [8:0] TX_MARKER = 9'h100;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_ARM = 2'h1,
    TX_WAIT = 2'h3,
    TX_SEND = 2'h2
  } ubs_tx_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_ARM = 2'h1,
    RX_PRIME = 2'h3,
    RX_RECV = 2'h2
  } ubs_rx_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ubs_bus_req_s;

  typedef struct packed {
    logic [3:0] phase;
    logic [7:0] sctrl;
    logic [7:0] pctrl;
    logic [7:0] tmode;
    logic [7:0] t1_reload;
    logic [7:0] t2ctrl;
    logic [7:0] ckmode;
    logic [7:0] rx_buf;
    logic [7:0] tx_hold;
    logic tx_pending;
    ubs_tx_e tx_st;
    logic [8:0] tx_shreg;
    logic tx_last;
    ubs_rx_e rx_st;
    logic [7:0] rx_shreg;
    logic rx_sample;
    logic rx_last;
    logic [6:0] base_cnt;
    logic [3:0] t1_pre;
    logic [7:0] t1_cnt;
    logic [6:0] t1ov_cnt;
    logic [3:0] t2tx_cnt;
    logic [3:0] t2rx_cnt;
    logic tx_tick;
    logic rx_tick;
    logic [7:0] rdata;
  } ubs_state_s;
endpackage

// >>> verilog/ubs_serial.sv
// Purpose: Serial port bit-rate selection and mode 0 shift-register sequencing.
// Assumes: clk_sys is the oscillator; all inputs are synchronous to it.
// Notes: Asynchronous framing for modes 1 to 3 lives elsewhere; this block
// only hands it the transmit and receive bit-rate ticks.
// Operation
// RQ1: Control register holds mode bits, ninth bits, transmit and receive done flags.
// RQ2: Mode 0 bit rate is oscillator over 12, or over 6 in six-clock mode.
// RQ3: Mode 2 rate is osc/64 or osc/32 by doubler; halved divisors in six-clock.
// RQ4: The baud doubler bit resets to zero.
// RQ5: Modes 1 and 3 take their rate from a timer overflow, never a fixed division.
// RQ6: Timer 1 source: doubler-scaled overflow rate over 32, or 16 in six-clock.
// RQ7: Software keeps timer 1 interrupt off when it sets the bit rate.
// RQ8: Auto-reload timer 1 overflows at osc over 12 times 256 minus reload.
// RQ9: Software may reload a 16-bit timer 1 by interrupt for slow rates.
// RQ10: Mode 0 moves eight bits LSB first on data line; clock line carries clock.
// RQ11: Buffer write at S6P2 starts mode 0 send and loads a marker one.
// RQ12: One full machine cycle passes between buffer write and send activation.
// RQ13: While sending, shift data and shift clock drive the two port lines.
// RQ14: Shift clock is low in S3 to S5 and high in S6, S1, S2.
// RQ15: Each S6P2 while sending, transmit register shifts right filling zeros.
// RQ16: Marker beside MSB forces last shift; done flag set at tenth cycle S1P1.
// RQ17: Receive starts when enabled and done clear; preload 11111110, then activate.
// RQ18: While receiving, shift clock drives its line, toggling at S3P1 and S6P1.
// RQ19: Each S6P2 while receiving, the receive register shifts one place.
// RQ20: Receive shift goes left, taking the data line sampled at S5P2.
// RQ21: Preload zero at left forces last shift, buffer load, done flag at S1P1.
// RQ22: Timer 2 clocks modes 1 and 3 only when its select bit is set.
// RQ23: Machine cycle is six states of two phases; six-clock runs a state per clock.
`timescale 1ns/1ps
module ubs_serial #(
  parameter int T1_PRESCALE = 12
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire ubs_pkg::ubs_bus_req_s bus_req,
  output logic [7:0] rd_data,
  input wire logic timer1_overflow_in,
  input wire logic timer2_overflow_in,
  input wire logic shift_data_in,
  output logic shift_data_out,
  output logic shift_data_oe_n,
  output logic shift_clock_out,
  output logic shift_clock_oe_n,
  output logic tx_bit_tick,
  output logic rx_bit_tick,
  output logic tx_active,
  output logic rx_active
);

  // The timer 1 prescaler counter is built for exactly one machine-cycle ratio.
  if (T1_PRESCALE != 12) begin : g_bad_prescale
    $error("T1_PRESCALE must be 12");
  end

  ubs_pkg::ubs_state_s s_reg;
  ubs_pkg::ubs_state_s s_next;

  // True when the current clock covers the given phase; six-clock mode runs a
  // whole state per clock, so both phases of a state share one cycle.
  function automatic logic at_phase(input logic [3:0] ph, input logic [3:0] tgt,
                                    input logic six);
    if (six) begin
      at_phase = (ph == {tgt[3:1], 1'b0});
    end else begin
      at_phase = (ph == tgt);
    end
  endfunction

  // Divisor scaled down by the doubler and by six-clock mode.
  function automatic logic [6:0] scaled_last(input logic [6:0] div, input logic dbl,
                                             input logic six);
    logic [6:0] d;
    d = div;
    if (dbl) begin
      d = d >> 1;
    end
    if (six) begin
      d = d >> 1;
    end
    scaled_last = d - 7'h01;
  endfunction

  // Bits enter on the right, so the first received bit ends leftmost.
  function automatic logic [7:0] reverse8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      reverse8[i] = v[7 - i];
    end
  endfunction

  logic six_clk;
  logic doubler;
  logic [1:0] mode;
  logic s6p2;
  logic s1p1;
  logic t1_ovf;
  logic t1_bit;
  logic t2tx_bit;
  logic t2rx_bit;
  logic mode2_bit;
  logic sending;
  logic receiving;

  assign six_clk = s_reg.ckmode[ubs_pkg::SIX_CLOCK_BIT];
  assign doubler = s_reg.pctrl[ubs_pkg::DOUBLER_BIT];
  assign mode = {s_reg.sctrl[ubs_pkg::MODE_HI_BIT], s_reg.sctrl[ubs_pkg::MODE_LO_BIT]};
  assign s6p2 = at_phase(s_reg.phase, ubs_pkg::PH_S6P2, six_clk);
  assign s1p1 = at_phase(s_reg.phase, ubs_pkg::PH_S1P1, six_clk);
  assign sending = (s_reg.tx_st == ubs_pkg::TX_SEND);
  assign receiving = (s_reg.rx_st == ubs_pkg::RX_RECV);

  // Next-state logic for the whole block.
  always_comb begin
    s_next = s_reg;
    s_next.tx_tick = 1'b0;
    s_next.rx_tick = 1'b0;
    s_next.rdata = 8'h00;
    t1_ovf = 1'b0;
    t1_bit = 1'b0;
    t2tx_bit = 1'b0;
    t2rx_bit = 1'b0;
    mode2_bit = 1'b0;

    // Phase sequencer; six-clock mode steps a whole state per clock.
    if (six_clk) begin // RQ23
      if ({s_reg.phase[3:1], 1'b0} >= ubs_pkg::PH_LAST - 4'h1) begin
        s_next.phase = ubs_pkg::PH_S1P1;
      end else begin
        s_next.phase = {s_reg.phase[3:1], 1'b0} + 4'h2;
      end
    end else if (s_reg.phase == ubs_pkg::PH_LAST) begin // RQ23
      s_next.phase = ubs_pkg::PH_S1P1;
    end else begin
      s_next.phase = s_reg.phase + 4'h1;
    end

    // Register writes; hardware flag sets below override a same-cycle clear.
    if (bus_req.wr) begin
      case (bus_req.addr)
        ubs_pkg::ADDR_SCTRL: begin
          s_next.sctrl = bus_req.wdata; // RQ1
        end
        ubs_pkg::ADDR_SER_BUF: begin
          s_next.tx_hold = bus_req.wdata;
          s_next.tx_pending = (mode == 2'h0);
        end
        ubs_pkg::ADDR_PCTRL: begin
          s_next.pctrl = bus_req.wdata;
        end
        ubs_pkg::ADDR_TMODE: begin
          s_next.tmode = bus_req.wdata;
        end
        ubs_pkg::ADDR_T1RLD: begin
          s_next.t1_reload = bus_req.wdata;
        end
        ubs_pkg::ADDR_T2CTRL: begin
          s_next.t2ctrl = bus_req.wdata;
        end
        ubs_pkg::ADDR_CKMODE: begin
          s_next.ckmode = bus_req.wdata;
        end
        default: begin
          s_next.rdata = 8'h00;
        end
      endcase
    end

    // Read data is presented for one cycle only, zero at unmapped addresses.
    if (bus_req.rd) begin
      case (bus_req.addr)
        ubs_pkg::ADDR_SCTRL: s_next.rdata = s_reg.sctrl;
        ubs_pkg::ADDR_SER_BUF: s_next.rdata = s_reg.rx_buf;
        ubs_pkg::ADDR_PCTRL: s_next.rdata = s_reg.pctrl;
        ubs_pkg::ADDR_TMODE: s_next.rdata = s_reg.tmode;
        ubs_pkg::ADDR_T1RLD: s_next.rdata = s_reg.t1_reload;
        ubs_pkg::ADDR_T2CTRL: s_next.rdata = s_reg.t2ctrl;
        ubs_pkg::ADDR_CKMODE: s_next.rdata = s_reg.ckmode;
        ubs_pkg::ADDR_STATUS: s_next.rdata = {4'h0, s_reg.tx_pending, s_reg.tx_last,
                                               receiving, sending};
        default: s_next.rdata = 8'h00;
      endcase
    end

    // Mode 2 rate: fixed oscillator division scaled by doubler and clock mode.
    if (s_reg.base_cnt >= scaled_last(ubs_pkg::MODE2_DIV, doubler, six_clk)) begin // RQ3
      s_next.base_cnt = 7'h00;
      mode2_bit = 1'b1;
    end else begin
      s_next.base_cnt = s_reg.base_cnt + 7'h01;
    end

    // Timer 1 counts every twelve oscillator periods in auto-reload mode.
    // Any other timer 1 mode is run outside and reports its overflow here.
    if (s_reg.t1_pre == ubs_pkg::T1_PRESCALE_LAST) begin
      s_next.t1_pre = 4'h0;
    end else begin
      s_next.t1_pre = s_reg.t1_pre + 4'h1;
    end
    if (s_reg.tmode[7:4] == ubs_pkg::T1_AUTO_RELOAD) begin
      if (s_reg.ckmode[ubs_pkg::T1_RUN_BIT] &&
          s_reg.t1_pre == ubs_pkg::T1_PRESCALE_LAST) begin
        if (s_reg.t1_cnt == 8'hFF) begin
          s_next.t1_cnt = s_reg.t1_reload; // RQ8
          t1_ovf = 1'b1; // RQ8
        end else begin
          s_next.t1_cnt = s_reg.t1_cnt + 8'h01;
        end
      end
    end else begin
      t1_ovf = timer1_overflow_in; // RQ5
    end

    // Timer 1 overflows divided by 32 or 16, halved again by the doubler.
    if (t1_ovf) begin
      if (s_reg.t1ov_cnt >= scaled_last(ubs_pkg::T1_BAUD_DIV, doubler, six_clk)) begin
        s_next.t1ov_cnt = 7'h00;
        t1_bit = 1'b1; // RQ6
      end else begin
        s_next.t1ov_cnt = s_reg.t1ov_cnt + 7'h01;
      end
    end

    // Timer 2 overflows divided by 16, with a separate counter for each direction.
    if (timer2_overflow_in) begin
      s_next.t2tx_cnt = s_reg.t2tx_cnt + 4'h1;
      s_next.t2rx_cnt = s_reg.t2rx_cnt + 4'h1;
      t2tx_bit = (s_reg.t2tx_cnt == ubs_pkg::T2_BAUD_LAST);
      t2rx_bit = (s_reg.t2rx_cnt == ubs_pkg::T2_BAUD_LAST);
    end

    // Bit-rate selection for each direction.
    case (mode)
      2'h0: begin
        s_next.tx_tick = s6p2; // RQ2
        s_next.rx_tick = s6p2; // RQ2
      end
      2'h2: begin
        s_next.tx_tick = mode2_bit; // RQ3
        s_next.rx_tick = mode2_bit; // RQ3
      end
      default: begin
        if (s_reg.t2ctrl[ubs_pkg::T2_TX_CLK_BIT]) begin
          s_next.tx_tick = t2tx_bit; // RQ22
        end else begin
          s_next.tx_tick = t1_bit; // RQ6
        end
        if (s_reg.t2ctrl[ubs_pkg::T2_RX_CLK_BIT]) begin
          s_next.rx_tick = t2rx_bit; // RQ22
        end else begin
          s_next.rx_tick = t1_bit; // RQ6
        end
      end
    endcase

    // Transmit sequencer for mode 0.
    case (s_reg.tx_st)
      ubs_pkg::TX_IDLE: begin
        if (s_reg.tx_pending && s6p2) begin
          // A buffer write in the take cycle stays pending, so its byte is not lost.
          if (!(bus_req.wr && bus_req.addr == ubs_pkg::ADDR_SER_BUF)) begin
            s_next.tx_pending = 1'b0;
          end
          s_next.tx_shreg = ubs_pkg::TX_MARKER | {1'b0, s_reg.tx_hold}; // RQ11
          s_next.tx_last = 1'b0;
          s_next.tx_st = ubs_pkg::TX_ARM; // RQ11
        end
      end
      ubs_pkg::TX_ARM: begin
        if (s6p2) begin
          s_next.tx_st = ubs_pkg::TX_WAIT; // RQ12
        end
      end
      ubs_pkg::TX_WAIT: begin
        if (s1p1) begin
          s_next.tx_st = ubs_pkg::TX_SEND; // RQ12
        end
      end
      ubs_pkg::TX_SEND: begin
        if (s1p1 && s_reg.tx_last) begin
          s_next.tx_st = ubs_pkg::TX_IDLE; // RQ16
          s_next.tx_last = 1'b0;
          s_next.sctrl[ubs_pkg::TX_DONE_BIT] = 1'b1; // RQ16
        end else if (s6p2) begin
          s_next.tx_shreg = {1'b0, s_reg.tx_shreg[8:1]}; // RQ15
          if (s_reg.tx_shreg[8:1] == 8'h01) begin
            s_next.tx_last = 1'b1; // RQ16
          end
        end
      end
      default: begin
        s_next.tx_st = ubs_pkg::TX_IDLE;
      end
    endcase

    // Receive sequencer for mode 0.
    case (s_reg.rx_st)
      ubs_pkg::RX_IDLE: begin
        if (mode == 2'h0 && s_reg.sctrl[ubs_pkg::RX_ENABLE_BIT] &&
            !s_reg.sctrl[ubs_pkg::RX_DONE_BIT] && s6p2) begin
          s_next.rx_st = ubs_pkg::RX_ARM; // RQ17
        end
      end
      ubs_pkg::RX_ARM: begin
        if (!s_reg.sctrl[ubs_pkg::RX_ENABLE_BIT]) begin
          s_next.rx_st = ubs_pkg::RX_IDLE;
        end else if (s6p2) begin
          s_next.rx_shreg = ubs_pkg::RX_PRELOAD; // RQ17
          s_next.rx_last = 1'b0;
          s_next.rx_st = ubs_pkg::RX_PRIME;
        end
      end
      ubs_pkg::RX_PRIME: begin
        s_next.rx_st = ubs_pkg::RX_RECV; // RQ17
      end
      ubs_pkg::RX_RECV: begin
        if (at_phase(s_reg.phase, ubs_pkg::PH_S5P2, six_clk)) begin
          s_next.rx_sample = shift_data_in; // RQ20
        end
        if (s1p1 && s_reg.rx_last) begin
          s_next.rx_st = ubs_pkg::RX_IDLE; // RQ21
          s_next.rx_last = 1'b0;
          s_next.sctrl[ubs_pkg::RX_DONE_BIT] = 1'b1; // RQ21
        end else if (s6p2 && !s_reg.rx_last) begin
          s_next.rx_shreg = {s_reg.rx_shreg[6:0], s_reg.rx_sample}; // RQ19 RQ20
          if (!s_reg.rx_shreg[7]) begin
            s_next.rx_last = 1'b1; // RQ21
            s_next.rx_buf = reverse8({s_reg.rx_shreg[6:0], s_reg.rx_sample}); // RQ10
          end
        end
      end
      default: begin
        s_next.rx_st = ubs_pkg::RX_IDLE;
      end
    endcase
  end

  // State register; everything, including the doubler bit, clears on reset.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0; // RQ4
    end else begin
      s_reg <= s_next;
    end
  end

  // Port alternate functions. The clock is high in S6, S1, S2 and low in S3 to
  // S5, so the far register sees stable data on the rising edge at S6P1.
  always_comb begin
    shift_clock_out = 1'b1;
    if (sending || receiving) begin
      shift_clock_out = !(s_reg.phase >= ubs_pkg::PH_S3P1 &&
                          s_reg.phase <= ubs_pkg::PH_S5P2); // RQ14 RQ18
    end
  end

  assign shift_clock_oe_n = !(sending || receiving); // RQ13 RQ18
  assign shift_data_out = sending ? s_reg.tx_shreg[0] : 1'b1; // RQ13 RQ10
  assign shift_data_oe_n = !sending; // RQ13
  assign rd_data = s_reg.rdata;
  assign tx_bit_tick = s_reg.tx_tick;
  assign rx_bit_tick = s_reg.rx_tick;
  assign tx_active = sending;
  assign rx_active = receiving;

endmodule

// >>> verification/ubs_serial_props.sv
// Purpose: Port-level checks on the serial shift and bit-rate block.
// Assumes: A machine cycle is 12 clocks, or 6 in six-clock mode.
// Notes: Frame spans are counted in helper registers, as they are too long to unroll.
`timescale 1ns/1ps
module ubs_serial_props #(
  parameter int T1_PRESCALE = 12
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic shift_data_out,
  input wire logic shift_data_oe_n,
  input wire logic shift_clock_out,
  input wire logic shift_clock_oe_n,
  input wire logic tx_bit_tick,
  input wire logic tx_active,
  input wire logic rx_active
);
  logic [7:0] tx_cnt_reg;
  logic [7:0] rx_cnt_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Counts how long each frame stays active, read back on the falling edge.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_cnt_reg <= 8'h00;
      rx_cnt_reg <= 8'h00;
    end else begin
      tx_cnt_reg <= tx_active ? tx_cnt_reg + 8'h01 : 8'h00;
      rx_cnt_reg <= rx_active ? rx_cnt_reg + 8'h01 : 8'h00;
    end
  end
  a_data_oe_send: assert property (shift_data_oe_n == !tx_active)
    else $error("data line drive does not follow sending");
  a_idle_data_high: assert property (shift_data_oe_n |-> shift_data_out)
    else $error("data line value low while released");
  a_clk_oe_busy: assert property (shift_clock_oe_n == !(tx_active || rx_active))
    else $error("clock line drive does not follow activity");
  a_idle_clk_high: assert property (shift_clock_oe_n |-> shift_clock_out)
    else $error("shift clock low while released");
  a_clk_low_span: assert property ($fell(shift_clock_out) |->
    (!shift_clock_out [*3] ##1 shift_clock_out) or (!shift_clock_out [*6] ##1 shift_clock_out))
    else $error("shift clock low span wrong");
  a_clk_fall_busy: assert property ($fell(shift_clock_out) |-> !shift_clock_oe_n)
    else $error("shift clock fell while idle");
  a_data_moves_high: assert property (!shift_data_oe_n && $past(shift_data_oe_n) == 1'b0 &&
    $changed(shift_data_out) |-> shift_clock_out)
    else $error("data changed while shift clock low");
  a_tx_span: assert property ($fell(tx_active) |-> tx_cnt_reg == 8'h60 || tx_cnt_reg == 8'h30)
    else $error("send span is not eight machine cycles");
  a_rx_span: assert property ($fell(rx_active) |-> rx_cnt_reg == 8'h60 || rx_cnt_reg == 8'h30)
    else $error("receive span is not eight machine cycles");
  a_tick_single: assert property (tx_bit_tick |=> !tx_bit_tick)
    else $error("bit tick longer than one cycle");
  c_send: cover property ($rose(tx_active));
  c_recv: cover property ($rose(rx_active));
  c_fast: cover property ($fell(tx_active) && tx_cnt_reg == 8'h30);
endmodule

bind ubs_serial ubs_serial_props #(.T1_PRESCALE(T1_PRESCALE)) i_props (
  .clk_sys(clk_sys), .resetn(resetn), .shift_data_out(shift_data_out),
  .shift_data_oe_n(shift_data_oe_n), .shift_clock_out(shift_clock_out),
  .shift_clock_oe_n(shift_clock_oe_n), .tx_bit_tick(tx_bit_tick),
  .tx_active(tx_active), .rx_active(rx_active)
);

// >>> verification/ubs_shift_partner.sv
// Purpose: External shift register clocked by the block's shift clock.
// Assumes: The shift clock is a registered output of clk_sys.
// Notes: A released data line shows the inverse of its last level.
`timescale 1ns/1ps
module ubs_shift_partner (
  input wire logic clk_sys,
  input wire logic data_out,
  input wire logic data_oe_n,
  input wire logic clock_out,
  input wire logic clock_oe_n,
  input wire logic [7:0] src_byte,
  output logic line_lvl,
  output logic [7:0] got_byte
);
  logic [7:0] src_reg;
  logic clk_last_reg;
  logic low_bit_reg;
  logic line_last_reg;
  // The partner drives only inside a receive frame; otherwise the line floats.
  assign line_lvl = !data_oe_n ? data_out : !clock_oe_n ? src_reg[0] : !line_last_reg;
  // Sampling while the clock is low avoids the shift that may land on the rising edge.
  always @(posedge clk_sys) begin
    clk_last_reg <= clock_out;
    line_last_reg <= line_lvl;
    if (!clock_out) low_bit_reg <= line_lvl;
    if (clock_oe_n) begin
      src_reg <= src_byte;
    end else if (clock_out && !clk_last_reg) begin
      if (data_oe_n) src_reg <= src_reg >> 1;
      else got_byte <= {low_bit_reg, got_byte[7:1]};
    end
  end
endmodule

// >>> verification/tb_ubs_serial.sv
// Purpose: Self-checking bench for the serial baud and shift block.
// Assumes: Registers are reached over the plain strobe port.
// Notes: Rate checks measure the third tick spacing, after the settings have settled.
`timescale 1ns/1ps
module tb_ubs_serial;
  logic clk_sys;
  logic resetn;
  ubs_pkg::ubs_bus_req_s bus_req;
  logic [7:0] rd_data, src_byte, got_byte;
  logic t1_en, t2_en, t1_ov, t2_ov, line_lvl;
  logic data_out, data_oe_n, clk_out, clk_oe_n, tx_tick, rx_tick, tx_active, rx_active;
  int n_mismatch = 0;
  int n_compared = 0;
  ubs_serial i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req), .rd_data(rd_data),
    .timer1_overflow_in(t1_ov), .timer2_overflow_in(t2_ov), .shift_data_in(line_lvl),
    .shift_data_out(data_out), .shift_data_oe_n(data_oe_n), .shift_clock_out(clk_out),
    .shift_clock_oe_n(clk_oe_n), .tx_bit_tick(tx_tick), .rx_bit_tick(rx_tick),
    .tx_active(tx_active), .rx_active(rx_active));
  ubs_shift_partner i_peer (
    .clk_sys(clk_sys), .data_out(data_out), .data_oe_n(data_oe_n), .clock_out(clk_out),
    .clock_oe_n(clk_oe_n), .src_byte(src_byte), .line_lvl(line_lvl), .got_byte(got_byte));
  // The clock runs at 20 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Enabled overflow inputs pulse every second clock, so edge or level counting agree.
  always @(posedge clk_sys) begin
    t1_ov <= t1_en & ~t1_ov;
    t2_ov <= t2_en & ~t2_ov;
  end
  task automatic cyc;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask
  task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_cnt(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      n_mismatch++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // The read data stand only in the cycle after the strobe edge.
  task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string nm);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 chk_val(nm, e, rd_data);
  endtask
  task automatic span(input bit rx, input int mc);
    int n;
    int m;
    n = 0;
    m = 0;
    while ((rx ? rx_active : tx_active) !== 1'b1 && n < 40) begin
      cyc();
      n++;
    end
    chk_cnt("start delay", 1, int'(n > mc && n <= 2 * mc + 2));
    while ((rx ? rx_active : tx_active) === 1'b1 && m < 200) begin
      cyc();
      m++;
    end
    chk_cnt("active span", 8 * mc, m);
  endtask
  task automatic t_regs;
    for (int a = 0; a < 8; a++) begin
      rchk(3'(a), 8'h00, "reset value");
    end
    wr(ubs_pkg::ADDR_STATUS, 8'hFF);
    rchk(ubs_pkg::ADDR_STATUS, 8'h00, "status after write");
    wr(ubs_pkg::ADDR_SCTRL, 8'hCC);
    rchk(ubs_pkg::ADDR_SCTRL, 8'hCC, "control bits");
  endtask
  task automatic t_send(input logic [7:0] b, input logic [7:0] ck, input int mc);
    wr(ubs_pkg::ADDR_CKMODE, ck);
    wr(ubs_pkg::ADDR_SCTRL, 8'h00);
    wr(ubs_pkg::ADDR_SER_BUF, b);
    span(1'b0, mc);
    chk_val("sent byte", b, got_byte);
    rchk(ubs_pkg::ADDR_SCTRL, 8'h02, "send done");
  endtask
  // A second reception must wait while the done flag is still set.
  task automatic t_recv;
    int n;
    n = 0;
    wr(ubs_pkg::ADDR_SCTRL, 8'h10);
    span(1'b1, 12);
    rchk(ubs_pkg::ADDR_SER_BUF, src_byte, "received byte");
    rchk(ubs_pkg::ADDR_SCTRL, 8'h11, "receive done");
    repeat (40) begin
      cyc();
      if (rx_active !== 1'b0) n++;
    end
    chk_cnt("held while done", 0, n);
  endtask
  // Both directions share one source in every setting used, so each measured
  // transmit interval must hold exactly one receive tick.
  task automatic rate(input logic [7:0] sc, pc, tm, rl, t2, ck, input logic o1, o2, input int e);
    int n;
    int r;
    n = 0;
    r = 0;
    wr(ubs_pkg::ADDR_SCTRL, sc);
    wr(ubs_pkg::ADDR_PCTRL, pc);
    wr(ubs_pkg::ADDR_TMODE, tm);
    wr(ubs_pkg::ADDR_T1RLD, rl);
    wr(ubs_pkg::ADDR_T2CTRL, t2);
    wr(ubs_pkg::ADDR_CKMODE, ck);
    t1_en <= o1;
    t2_en <= o2;
    for (int k = 0; k < 3; k++) begin
      cyc();
      n = 1;
      r = 0;
      while (tx_tick !== 1'b1 && n < 4000) begin
        r += int'(rx_tick === 1'b1);
        cyc();
        n++;
      end
      r += int'(rx_tick === 1'b1);
    end
    chk_cnt("tick spacing", e, n);
    chk_cnt("receive ticks", 1, r);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // The tests need about 8000 cycles; the watchdog allows several times that.
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end
  initial begin
    resetn = 1'b0;
    bus_req = '0;
    t1_en = 1'b0;
    t2_en = 1'b0;
    t1_ov = 1'b0;
    t2_ov = 1'b0;
    src_byte = 8'h3C;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs();
    t_send(8'hA5, 8'h00, 12);
    t_recv();
    t_send(8'h96, 8'h01, 6);
    rate(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 12);
    rate(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 1'b0, 1'b0, 6);
    rate(8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 64);
    rate(8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 32);
    rate(8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h01, 1'b0, 1'b0, 16);
    rate(8'h40, 8'h00, 8'h20, 8'hFF, 8'h00, 8'h02, 1'b0, 1'b0, 12 * 1 * 32);
    rate(8'hC0, 8'h80, 8'h20, 8'hFD, 8'h00, 8'h02, 1'b0, 1'b0, 12 * 3 * 16);
    rate(8'h40, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 2 * 32);
    rate(8'h40, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 1'b0, 1'b1, 2 * 16);
    complete_run();
  end
endmodule
